// file: core/ucs_defines.svh
// Purpose: Named offsets, field positions and reset values of the serial control registers
// Assumes: Included by bare name from every design file that needs it
// Notes:   Definitions only
`ifndef UCS_DEFINES_SVH
`define UCS_DEFINES_SVH

// Byte addresses on the APB, one aligned word each
`define UCS_AW            12
`define UCS_OFF_CSR       12'h000
`define UCS_OFF_LINE      12'h004
`define UCS_OFF_DBUF      12'h008

// Control/status field positions
`define UCS_CSR_MODE      7
`define UCS_CSR_RX_ON     6
`define UCS_CSR_SLAVE     5
`define UCS_CSR_FE        4
`define UCS_CSR_PE        3
`define UCS_CSR_RXB       2
`define UCS_CSR_TXB       1
`define UCS_CSR_BUSY      0

// Line control field positions
`define UCS_LN_FLUSH      7
`define UCS_LN_FLOW       6
`define UCS_LN_SENSE      5
`define UCS_LN_NINTH      4
`define UCS_LN_PARITY     3
`define UCS_LN_TWO_END    2
`define UCS_LN_STOP       1
`define UCS_LN_START      0

// Reset values
`define UCS_CSR_RST       8'h00
`define UCS_LINE_RST      7'h02
`define UCS_DBUF_RST      8'h00

// Sticky flag slots in the flag bank
`define UCS_NFLAG         4
`define UCS_F_FE          0
`define UCS_F_PE          1
`define UCS_F_RXB         2
`define UCS_F_TXB         3

`endif

// file: core/ucs_pkg.sv
// Purpose: Types shared by the serial control register files
// Assumes: Constants live in ucs_defines.svh
// Notes:   Nothing here is imported; users write ucs_pkg::name
package ucs_pkg;

  // Which register an APB address selects
  typedef enum logic [1:0] {
    sel_none,
    sel_csr,
    sel_line,
    sel_dbuf
  } ucs_sel_e;

  // Stored line control settings, flush excluded
  typedef struct packed {
    logic flow_on;
    logic parity_sense;
    logic ninth_bit_enable;
    logic parity_enable;
    logic two_end_bits;
    logic stop_level;
    logic start_level;
  } ucs_line_s;

endpackage : ucs_pkg

// file: core/ucs_flag_if.sv
// Purpose: Carries set, clear and state of the sticky status flags
// Assumes: One bit per flag slot
// Notes:   Between the register file and its flag bank only
`include "ucs_defines.svh"

interface ucs_flag_if;
  logic [`UCS_NFLAG-1:0] set;
  logic [`UCS_NFLAG-1:0] clr;
  logic [`UCS_NFLAG-1:0] q;

  modport ctl (output set, output clr, input q);
  modport bank (input set, input clr, output q);
endinterface : ucs_flag_if

// file: core/ucs_flags.sv
// Purpose: Bank of sticky status flags
// Assumes: Set and clear are one-cycle pulses from the register file
// Notes:   A set in the clear cycle survives, so no event is dropped
`include "ucs_defines.svh"

module ucs_flags (
  input  wire logic pclk,
  input  wire logic presetn,
  ucs_flag_if.bank  f
);

  genvar i;
  generate
    for (i = 0; i < `UCS_NFLAG; i++) begin : g_flag
      logic q;
      logic next_q;

      // Set dominates clear
      always_comb begin
        next_q = f.set[i] | (q & ~f.clr[i]);
      end

      // Flag storage
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          q <= 1'b0;
        end else begin
          q <= next_q;
        end
      end

      assign f.q[i] = q;
    end
  endgenerate

endmodule // ucs_flags

// file: core/ucs_regs.sv
// Purpose: Control and status registers of a dual-mode UART / SPI serial unit on APB
// Assumes: Shifter, baud generator and data buffer sit outside and talk over plain ports
// Notes:   Zero-wait APB slave; read data is captured in the setup cycle
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`include "ucs_defines.svh"

module ucs_regs (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [`UCS_AW-1:0]    paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // Shifter events and state
  input  wire logic                  rx_done,
  input  wire logic [7:0]            rx_data,
  input  wire logic                  rx_frame_bad,
  input  wire logic                  rx_parity_bad,
  input  wire logic                  tx_done,
  input  wire logic                  shift_busy,
  input  wire logic                  ssn_n,
  // Settings to the shifter
  output logic                       uart_mode,
  output logic                       rx_on,
  output logic                       spi_slave,
  output logic                       flow_on,
  output logic                       parity_sense,
  output logic                       ninth_bit_enable,
  output logic                       parity_on,
  output logic                       two_end_bits,
  output logic                       stop_level,
  output logic                       start_level,
  // Commands to the shifter
  output logic                       flush,
  output logic                       tx_load,
  output logic [7:0]                 tx_data,
  output logic                       rx_discard
);

  ucs_flag_if        fl ();
  ucs_pkg::ucs_sel_e sel;
  ucs_pkg::ucs_line_s line;
  ucs_pkg::ucs_line_s next_line;

  logic       setup;
  logic       wr;
  logic       rd;
  logic       busy;
  logic       mode;
  logic       role;
  logic       next_mode;
  logic       next_rx_on;
  logic       next_role;
  logic [7:0] csr_view;
  logic [31:0] next_prdata;
  logic       next_flush;
  logic       next_tx_load;
  logic [7:0] next_tx_data;
  logic       next_rx_discard;
  logic       wr_csr;
  logic       wr_line;
  logic       wr_dbuf;
  logic       rd_csr;
  logic       rd_dbuf;
  logic [7:0] line_view;

  // Access timing of one transfer:
  //   setup edge  - read data captured from the live register image
  //   access edge - writes land and read side effects fire
  //   next edge   - command pulses reach the shifter for one cycle
  // Read data therefore shows state from one cycle before the access edge.
  // Back-to-back transfers need no idle cycle between them.

  // Zero-wait slave: every access phase completes in its first cycle
  // No register needs a second cycle, so pready is never pulled low
  // A wait state would only add latency to status polling
  assign pready = 1'b1;
  assign setup  = psel & ~penable;
  assign wr     = psel & penable & pwrite;
  assign rd     = psel & penable & ~pwrite;

  // Address decode; addresses are stable over both phases
  // Only exact word addresses hit; other byte addresses are unmapped
  // Upper address bits are decoded too, so no register is aliased
  always_comb begin
    if (paddr == `UCS_OFF_CSR) begin
      sel = ucs_pkg::sel_csr;
    end else if (paddr == `UCS_OFF_LINE) begin
      sel = ucs_pkg::sel_line;
    end else if (paddr == `UCS_OFF_DBUF) begin
      sel = ucs_pkg::sel_dbuf;
    end else begin
      sel = ucs_pkg::sel_none;
    end
  end

  // Unmapped addresses answer with an error and change nothing
  assign pslverr = psel & penable & (sel == ucs_pkg::sel_none);

  // Per-register strobes of the access phase
  // Side effects below key off these rather than repeating the decode
  assign wr_csr  = wr & (sel == ucs_pkg::sel_csr);
  assign wr_line = wr & (sel == ucs_pkg::sel_line);
  assign wr_dbuf = wr & (sel == ucs_pkg::sel_dbuf);
  assign rd_csr  = rd & (sel == ucs_pkg::sel_csr);
  assign rd_dbuf = rd & (sel == ucs_pkg::sel_dbuf);

  // Slave select is active low, so a selected slave is busy
  // A slave cannot tell frame ends itself, so the select stands in for them
  // The select is taken as already synchronous to the clock
  always_comb begin
    if (!mode && role) begin
      busy = ~ssn_n;
    end else begin
      busy = shift_busy;
    end
  end

  // Live view of the control/status register
  always_comb begin
    csr_view                = `UCS_CSR_RST;
    csr_view[`UCS_CSR_MODE]  = mode;
    csr_view[`UCS_CSR_RX_ON] = rx_on;
    csr_view[`UCS_CSR_SLAVE] = role;
    csr_view[`UCS_CSR_FE]    = fl.q[`UCS_F_FE];
    csr_view[`UCS_CSR_PE]    = fl.q[`UCS_F_PE];
    csr_view[`UCS_CSR_RXB]   = fl.q[`UCS_F_RXB];
    csr_view[`UCS_CSR_TXB]   = fl.q[`UCS_F_TXB];
    csr_view[`UCS_CSR_BUSY]  = busy;
  end

  // Mode and role bits
  // A mode change takes effect at once; software flushes first if a byte is in flight
  always_comb begin
    next_mode  = mode;
    next_rx_on = rx_on;
    next_role  = role;
    if (wr_csr) begin
      next_mode  = pwdata[`UCS_CSR_MODE];
      next_rx_on = pwdata[`UCS_CSR_RX_ON];
      next_role  = pwdata[`UCS_CSR_SLAVE];
    end
  end

  // Mode, receiver enable and role registers
  // All reset to SPI master with the receiver off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode  <= 1'b0;
      rx_on <= 1'b0;
      role  <= 1'b0;
    end else begin
      mode  <= next_mode;
      rx_on <= next_rx_on;
      role  <= next_role;
    end
  end

  // Mode and role go to the shifter straight from their flops
  // so the shifter never sees a decode glitch
  assign uart_mode = mode;
  assign spi_slave = role;

  // Line control settings; flush is a command, not a stored bit
  // Stop and start levels are stored as written: keeping them opposite
  // is left to software, a clash is not caught here
  // A flush write also rewrites the settings held in the same word
  always_comb begin
    next_line = line;
    if (wr_line) begin
      next_line.flow_on          = pwdata[`UCS_LN_FLOW];
      next_line.parity_sense     = pwdata[`UCS_LN_SENSE];
      next_line.ninth_bit_enable = pwdata[`UCS_LN_NINTH];
      next_line.parity_enable    = pwdata[`UCS_LN_PARITY];
      next_line.two_end_bits     = pwdata[`UCS_LN_TWO_END];
      next_line.stop_level       = pwdata[`UCS_LN_STOP];
      next_line.start_level      = pwdata[`UCS_LN_START];
    end
  end

  // Line control register; only the stop level resets high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line <= `UCS_LINE_RST;
    end else begin
      line <= next_line;
    end
  end

  // Settings to the shifter
  assign flow_on          = line.flow_on;
  assign parity_sense     = line.parity_sense;
  assign ninth_bit_enable = line.ninth_bit_enable;
  assign two_end_bits     = line.two_end_bits;
  assign stop_level       = line.stop_level;
  assign start_level      = line.start_level;
  // Parity enable alone is inert; the ninth bit must exist to carry it
  assign parity_on = line.parity_enable & line.ninth_bit_enable;

  // Sticky status flags, one slot each in the flag bank:
  //   framing error - set in UART mode only
  //   parity error  - set in UART mode with parity really computed
  //   received byte - set in UART mode or as an SPI slave
  //   sent byte     - set in UART mode or as an SPI master
  // Every clear comes from the bus or a flush; the bank lets a set win.

  // Flag events from the shifter, gated by the mode they belong to
  // An event of the other mode is dropped, not kept for later
  always_comb begin
    fl.set                = '0;
    fl.set[`UCS_F_FE]     = rx_frame_bad & mode;
    fl.set[`UCS_F_PE]     = rx_parity_bad & mode & parity_on;
    fl.set[`UCS_F_RXB]    = rx_done & (mode | role);
    fl.set[`UCS_F_TXB]    = tx_done & (mode | ~role);
  end

  // Flag clears. A read clears only what it returned as 1, so an error
  // that lands between the setup and access edges is still reported.
  // Reads and writes never meet in one cycle, and a same-cycle set still wins.
  always_comb begin
    fl.clr = '0;
    // Error flags go once a read has shown them
    if (rd_csr) begin
      fl.clr[`UCS_F_FE] = prdata[`UCS_CSR_FE];
      fl.clr[`UCS_F_PE] = prdata[`UCS_CSR_PE];
    end
    // A written 0 clears, a written 1 leaves the flag as it is
    if (wr_csr) begin
      fl.clr[`UCS_F_FE]  = ~pwdata[`UCS_CSR_FE];
      fl.clr[`UCS_F_PE]  = ~pwdata[`UCS_CSR_PE];
      fl.clr[`UCS_F_RXB] = ~pwdata[`UCS_CSR_RXB];
      fl.clr[`UCS_F_TXB] = ~pwdata[`UCS_CSR_TXB];
    end
    // Reading the received byte consumes it
    if (rd_dbuf) begin
      fl.clr[`UCS_F_RXB] = 1'b1;
    end
    // A flush empties the receive side as well
    if (flush) begin
      fl.clr[`UCS_F_RXB] = 1'b1;
    end
  end

  // Flag storage; set beats clear inside the bank
  ucs_flags u_flags (
    .pclk    (pclk),
    .presetn (presetn),
    .f       (fl.bank)
  );

  // Readback image of the line control register
  // Built once so the read mux stays one line per register
  always_comb begin
    line_view                  = '0;
    line_view[`UCS_LN_FLUSH]   = 1'b0;
    line_view[`UCS_LN_FLOW]    = line.flow_on;
    line_view[`UCS_LN_SENSE]   = line.parity_sense;
    line_view[`UCS_LN_NINTH]   = line.ninth_bit_enable;
    line_view[`UCS_LN_PARITY]  = line.parity_enable;
    line_view[`UCS_LN_TWO_END] = line.two_end_bits;
    line_view[`UCS_LN_STOP]    = line.stop_level;
    line_view[`UCS_LN_START]   = line.start_level;
  end

  // Read data is taken at the setup edge so it is stable in the access phase
  // The read-clear of error flags relies on this captured value
  // Unmapped addresses return zero alongside the error response
  always_comb begin
    next_prdata = prdata;
    if (setup && !pwrite) begin
      next_prdata = '0;
      if (sel == ucs_pkg::sel_csr) begin
        next_prdata[7:0] = csr_view;
      end else if (sel == ucs_pkg::sel_line) begin
        next_prdata[7:0] = line_view;
      end else if (sel == ucs_pkg::sel_dbuf) begin
        next_prdata[7:0] = rx_data;
      end
    end
  end

  // Read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else begin
      prdata <= next_prdata;
    end
  end

  // Command pulses and transmit byte, one cycle after the write edge
  // Registering them keeps the shifter off the combinational bus decode
  // A discard is only issued when there was a byte to throw away
  // The transmit byte holds until the next load; nothing buffers a second one
  always_comb begin
    next_flush      = wr_line & pwdata[`UCS_LN_FLUSH];
    next_tx_load    = wr_dbuf;
    next_rx_discard = wr_csr & ~pwdata[`UCS_CSR_RXB] & fl.q[`UCS_F_RXB];
    next_tx_data    = tx_data;
    if (next_tx_load) begin
      next_tx_data = pwdata[7:0];
    end
  end

  // Command pulse and transmit byte registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flush      <= 1'b0;
      tx_load    <= 1'b0;
      rx_discard <= 1'b0;
      tx_data    <= `UCS_DBUF_RST;
    end else begin
      flush      <= next_flush;
      tx_load    <= next_tx_load;
      rx_discard <= next_rx_discard;
      tx_data    <= next_tx_data;
    end
  end

endmodule // ucs_regs

// file: testbench/ucs_shift_model.sv
// Purpose: Shifter stand-in on the far side of the register block
// Assumes: Fixed 20-cycle byte time; flush drops the byte in flight
// Notes:   The received byte stays on rx_data until the next one arrives
module ucs_shift_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tx_load,
  input  wire logic       flush,
  input  wire logic       go_rx,
  input  wire logic [9:0] go_val,
  output logic            rx_done,
  output logic [7:0]      rx_data,
  output logic            rx_frame_bad,
  output logic            rx_parity_bad,
  output logic            tx_done,
  output logic            shift_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] cnt;
  logic       rx_mode;
  logic [9:0] val;

  // One byte in flight at a time, either direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {cnt, rx_mode, val, rx_done, rx_data, rx_frame_bad, rx_parity_bad, tx_done} <= '0;
    end else begin
      {rx_done, tx_done, rx_frame_bad, rx_parity_bad} <= 4'h0;
      if (flush) begin
        cnt <= 5'h00;
      end else if (tx_load || go_rx) begin
        cnt <= 5'h14;
        rx_mode <= go_rx;
        val <= go_val;
      end else if (cnt == 5'h01) begin
        cnt <= 5'h00;
        if (rx_mode) begin
          {rx_parity_bad, rx_frame_bad, rx_data} <= val;
          rx_done <= 1'h1;
        end else begin
          tx_done <= 1'h1;
        end
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end
    end
  end
  assign shift_busy = (cnt != 5'h00);
endmodule // ucs_shift_model

// file: testbench/ucs_regs_assertions.sv
// Purpose: Port-level checks of the serial control registers
// Assumes: Bound to ucs_regs; zero-wait APB
// Notes:   Flag checks read status right after the event, before other traffic
`include "ucs_defines.svh"
module ucs_regs_chk (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [`UCS_AW-1:0] paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pslverr,
  input wire logic               rx_done,
  input wire logic               rx_frame_bad,
  input wire logic               rx_parity_bad,
  input wire logic               shift_busy,
  input wire logic               ssn_n,
  input wire logic               uart_mode,
  input wire logic               rx_on,
  input wire logic               spi_slave,
  input wire logic               flow_on,
  input wire logic               parity_sense,
  input wire logic               ninth_bit_enable,
  input wire logic               parity_on,
  input wire logic               two_end_bits,
  input wire logic               stop_level,
  input wire logic               start_level,
  input wire logic               flush,
  input wire logic               rx_discard
);
  timeunit 1ns;
  timeprecision 100ps;
  logic rc, ws, wc, wl, bz;
  // Decoded bus phases and expected busy source
  assign rc = psel && !penable && !pwrite && paddr == `UCS_OFF_CSR;
  assign ws = psel && !penable && pwrite && paddr == `UCS_OFF_CSR && !pwdata[2];
  assign wc = psel && penable && pwrite && paddr == `UCS_OFF_CSR;
  assign wl = psel && penable && pwrite && paddr == `UCS_OFF_LINE;
  assign bz = (!uart_mode && spi_slave) ? !ssn_n : shift_busy;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_mode_bits: assert property (wc |=> {uart_mode, rx_on, spi_slave} == $past(pwdata[7:5]))
    else $error("mode bits not stored");
  chk_line_bits: assert property (wl |=> {flow_on, parity_sense, ninth_bit_enable, two_end_bits,
    stop_level, start_level} == {$past(pwdata[6:4]), $past(pwdata[2:0])}) else $error("line bits wrong");
  chk_parity_gate: assert property (wl |=> parity_on == ($past(pwdata[3]) && $past(pwdata[4])))
    else $error("parity enable not gated");
  chk_flush_pulse: assert property (wl && pwdata[7] |=> flush ##1 !flush)
    else $error("flush not one pulse");
  chk_busy_read: assert property (rc |=> prdata[0] == $past(bz))
    else $error("busy bit wrong");
  chk_frame_flag: assert property (uart_mode && rx_frame_bad ##1 !psel ##1 rc |=> prdata[4])
    else $error("framing flag missing");
  chk_parity_flag: assert property (uart_mode && parity_on && rx_parity_bad ##1 !psel ##1 rc |=> prdata[3])
    else $error("parity flag missing");
  chk_rx_flag: assert property ((uart_mode || spi_slave) && rx_done ##1 !psel ##1 rc |=> prdata[2])
    else $error("received flag missing");
  chk_discard_cmd: assert property (uart_mode && rx_done ##1 !psel ##1 ws ##1 wc |=> rx_discard)
    else $error("discard not issued");

  cover property (wl && pwdata[7]);
  cover property (rx_discard);
  cover property (psel && penable && pslverr);
endmodule // ucs_regs_chk

bind ucs_regs ucs_regs_chk i_ucs_regs_chk (.*);

// file: testbench/tb.sv
// Purpose: Self-checking bench of the serial control registers
// Assumes: Zero-wait APB slave, shifter model on the far side
// Notes:   Reads and byte loads are checked from queues by a monitor
`include "ucs_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, ssn_n, go_rx;
  logic [`UCS_AW-1:0] paddr;
  logic [31:0]        pwdata, prdata;
  logic [9:0]         go_val;
  logic [7:0]         rx_data, tx_data, d;
  logic               rx_done, rx_frame_bad, rx_parity_bad, tx_done, shift_busy, flush;
  logic               uart_mode, rx_on, spi_slave, flow_on, parity_sense, ninth_bit_enable;
  logic               parity_on, two_end_bits, stop_level, start_level, tx_load, rx_discard;
  logic [32:0]        rq[$];
  logic [7:0]         tq[$];
  int                 fails, compares;

  ucs_regs i_ucs_regs (.*);
  ucs_shift_model i_ucs_shift_model (.*);

  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end

  task automatic bad(input string s);
    $display("MISMATCH t=%0t %s", $time, s);
    fails++;
  endtask

  task automatic close_out();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Setup, then access held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] v);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 40);
    if (pready !== 1'h1) begin
      bad("bus timeout");
      close_out();
    end
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    rq.push_back({a > `UCS_OFF_DBUF, 24'h0, e});
    apb(1'h0, a, 8'h00);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    if (a == `UCS_OFF_DBUF) tq.push_back(v);
    apb(1'h1, a, v);
  endtask

  // Bounded wait for a shifter completion pulse
  task automatic await(input logic rx);
    int n;
    n = 0;
    while ((rx ? rx_done : tx_done) !== 1'h1 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 60) begin
      bad("shifter timeout");
      close_out();
    end
    @(posedge pclk);
  endtask

  task automatic rx(input logic [9:0] v);
    go_rx <= 1'h1;
    go_val <= v;
    @(posedge pclk);
    go_rx <= 1'h0;
    await(1'h1);
  endtask

  task automatic cmp_rd(input logic [32:0] e);
    compares++;
    if ({pslverr, prdata} !== e) bad("read data");
  endtask

  task automatic cmp_tx(input logic [7:0] e);
    compares++;
    if (tx_data !== e) bad("transmit byte");
  endtask

  // Monitor takes the oldest note whenever a result shows
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (rq.size() == 0) bad("unexpected read");
      else cmp_rd(rq.pop_front());
    end
    if (tx_load === 1'h1) begin
      if (tq.size() == 0) bad("unexpected load");
      else cmp_tx(tq.pop_front());
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, go_rx, go_val} = '0;
    ssn_n = 1'h1;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    void'($urandom(32'h721f515a));
    rd(`UCS_OFF_CSR, 8'h00);
    rd(`UCS_OFF_LINE, 8'h02);
    rd(12'h00c, 8'h00);
    $display("test reset done");
    // Random line settings with start and stop kept opposite
    repeat (4) begin
      d = 8'($urandom());
      d = {1'h0, d[6:2], ~d[0], d[0]};
      wr(`UCS_OFF_LINE, d);
      rd(`UCS_OFF_LINE, d);
    end
    // Every mode and role; ones to status bits are ignored
    for (int i = 0; i < 8; i++) begin
      wr(`UCS_OFF_CSR, {3'(i), 5'h1e});
      rd(`UCS_OFF_CSR, {3'(i), 5'h00});
    end
    $display("test config done");
    wr(`UCS_OFF_LINE, 8'h1a);
    wr(`UCS_OFF_CSR, 8'hc0);
    d = 8'($urandom());
    rx({2'h3, d});
    rd(`UCS_OFF_CSR, 8'hdc);
    rd(`UCS_OFF_CSR, 8'hc4);
    rd(`UCS_OFF_DBUF, d);
    rd(`UCS_OFF_CSR, 8'hc0);
    wr(`UCS_OFF_LINE, 8'h0a);
    rx({2'h2, 8'($urandom())});
    wr(`UCS_OFF_CSR, 8'hc0);
    rd(`UCS_OFF_CSR, 8'hc0);
    d = 8'($urandom());
    rx({2'h1, d});
    wr(`UCS_OFF_CSR, 8'hd4);
    wr(`UCS_OFF_CSR, 8'hc4);
    rd(`UCS_OFF_CSR, 8'hc4);
    rd(`UCS_OFF_DBUF, d);
    $display("test receive done");
    d = 8'($urandom());
    wr(`UCS_OFF_DBUF, d);
    rd(`UCS_OFF_CSR, 8'hc1);
    await(1'h0);
    rd(`UCS_OFF_CSR, 8'hc2);
    wr(`UCS_OFF_CSR, 8'hc2);
    rd(`UCS_OFF_CSR, 8'hc2);
    wr(`UCS_OFF_CSR, 8'hc0);
    rd(`UCS_OFF_CSR, 8'hc0);
    wr(`UCS_OFF_DBUF, 8'($urandom()));
    wr(`UCS_OFF_LINE, 8'h82);
    repeat (30) @(posedge pclk);
    rd(`UCS_OFF_CSR, 8'hc0);
    rd(`UCS_OFF_LINE, 8'h02);
    $display("test transmit done");
    wr(`UCS_OFF_CSR, 8'h20);
    ssn_n <= 1'h0;
    @(posedge pclk);
    rd(`UCS_OFF_CSR, 8'h21);
    ssn_n <= 1'h1;
    @(posedge pclk);
    rd(`UCS_OFF_CSR, 8'h20);
    $display("test slave done");
    close_out();
  end
endmodule // tb
